// ### verilog/ccsr_pkg.sv
// ccsr_pkg: constants shared by both ends of the context save and
// restore dialogue. assumes nothing of its surroundings.
package ccsr_pkg;

   // interface register selects
   typedef enum logic [1:0] {
      CCSR_SEL_SAVE = 2'h0,
      CCSR_SEL_RESTORE = 2'h1,
      CCSR_SEL_CONTROL = 2'h2,
      CCSR_SEL_OPERAND = 2'h3
   } ccsr_sel_t;

   // format word layout: code in upper byte, length in lower byte
   localparam int CCSR_CODE_MSB = 15;
   localparam int CCSR_CODE_LSB = 8;
   localparam int CCSR_LEN_MSB = 7;
   localparam int CCSR_LEN_LSB = 0;
   localparam logic [7:0] CCSR_CODE_EMPTY = 8'h00;
   localparam logic [7:0] CCSR_CODE_NOT_READY = 8'h01;
   localparam logic [7:0] CCSR_CODE_INVALID = 8'h02;
   localparam logic [7:0] CCSR_CODE_VALID_MIN = 8'h10;
   localparam logic [15:0] CCSR_FMT_INVALID = 16'h0200;
   localparam logic [15:0] CCSR_FMT_NOT_READY = 16'h0100;

   // abort mask: low two bits 01, upper fourteen bits don't care
   localparam logic [1:0] CCSR_ABORT_BITS = 2'h1;
   localparam logic [15:0] CCSR_ABORT_MASK = 16'h0001;

   // save operation word fields
   localparam logic [3:0] CCSR_OP_FLINE = 4'hf;
   localparam logic [2:0] CCSR_OP_SAVE = 3'h4;
   localparam int CCSR_MAX_EXT = 5;

   // effective address mode numbers, and register numbers for the absolute modes under mode 7
   localparam logic [2:0] CCSR_EA_IND = 3'h2;
   localparam logic [2:0] CCSR_EA_PREDEC = 3'h4;
   localparam logic [2:0] CCSR_EA_DISP = 3'h5;
   localparam logic [2:0] CCSR_EA_INDEX = 3'h6;
   localparam logic [2:0] CCSR_EA_OTHER = 3'h7;
   localparam logic [2:0] CCSR_EA_ABS_W = 3'h0;
   localparam logic [2:0] CCSR_EA_ABS_L = 3'h1;

   typedef enum logic [1:0] {
      CCSR_K_EMPTY = 2'h0,
      CCSR_K_NOT_READY = 2'h1,
      CCSR_K_INVALID = 2'h2,
      CCSR_K_VALID = 2'h3
   } ccsr_kind_t;

   // classify a format word; reserved codes count as invalid
   function automatic ccsr_kind_t ccsr_kind(input logic [15:0] fw);
      logic [7:0] c;
      c = fw[CCSR_CODE_MSB:CCSR_CODE_LSB];
      if (c == CCSR_CODE_EMPTY)
         return CCSR_K_EMPTY;
      else if (c == CCSR_CODE_NOT_READY)
         return CCSR_K_NOT_READY;
      else if (c >= CCSR_CODE_VALID_MIN)
         return CCSR_K_VALID;
      else
         return CCSR_K_INVALID;
   endfunction

   // length field is usable only when a multiple of four
   function automatic logic ccsr_len_bad(input logic [15:0] fw);
      return fw[CCSR_LEN_LSB+1:CCSR_LEN_LSB] != 2'h0;
   endfunction

endpackage

// ### verilog/ccsr_if.sv
// ccsr_if: interface register port between the main processor end and
// the coprocessor end. one request at a time; the coprocessor answers
// each taken request with a one-cycle ack one clock later.
`timescale 1ns/1ps
interface ccsr_if
   import ccsr_pkg::*;
   (input wire logic clk_sys, input wire logic rst);
   logic req;
   logic wr;
   ccsr_sel_t sel;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;

   modport main (input clk_sys, rst, ack, rdata,
      output req, wr, sel, wdata);
   modport cop (input clk_sys, rst, req, wr, sel, wdata,
      output ack, rdata);
endinterface

// ### verilog/ccsr_main.sv
// ccsr_main: main processor end of the context save/restore dialogue.
// decodes the save operation word, gathers extension words, runs the
// save and restore format-word exchange and the abort path.
// assumes the coprocessor end answers every request on the ccsr_if.
// Overview of operation
// RULE1 - save begins by reading the save register
// RULE2 - save not-ready: service interrupts, read again
// RULE3 - coprocessor suspends or finishes after not-ready
// RULE4 - coprocessor resumes suspended instruction after restore
// RULE5 - restore write makes coprocessor stop and accept
// RULE6 - coprocessor returns restore not-ready only if needed
// RULE7 - restore not-ready: reread at once, no interrupts
// RULE8 - coprocessor flags bad restore frame as invalid
// RULE9 - restore invalid: write abort mask, format error
// RULE10 - abort mask low bits are 01
// RULE11 - coprocessor may refuse save during save/restore
// RULE12 - save invalid: write abort mask, format error
// RULE13 - save frame size from valid word low byte
// RULE14 - restore size from memory format word length
// RULE15 - length not multiple of four aborts
// RULE16 - save opword: f-line, select, 100, ea
// RULE17 - only control-alterable or predecrement, else f-line trap
// RULE18 - accept up to five extension words
// RULE19 - code upper byte, length lower byte
// RULE20 - code classes: empty, not-ready, invalid, valid
`timescale 1ns/1ps
module ccsr_main
   import ccsr_pkg::*;
   (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // link to the coprocessor
   ccsr_if.main cir,
   // save instruction
   input wire logic save_start,
   input wire logic [15:0] save_opword,
   input wire logic [2:0] coproc_select_field,
   input wire logic ext_valid,
   input wire logic [15:0] ext_word,
   input wire logic [31:0] areg_value,
   // context_restore_instr
   input wire logic restore_start,
   input wire logic [15:0] restore_fmt,
   // interrupt service handshake
   input wire logic irq_done,
   output logic irq_service,
   // results
   output logic done,
   output logic [7:0] frame_len,
   output logic [15:0] save_fmt,
   output logic [31:0] frame_ea,
   output logic fmt_error,
   output logic fline_exc,
   output logic busy
   );

   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_EXT = 8'h02,
      S_SAVE_RD = 8'h04,
      S_IRQ = 8'h08,
      S_RST_WR = 8'h10,
      S_RST_RD = 8'h20,
      S_ABORT = 8'h40,
      S_FIN = 8'h80
   } ccsr_st_t;

   // extension words needed by a save effective address
   function automatic logic [2:0] ext_need(input logic [5:0] ea,
      input logic [15:0] first);
      logic [2:0] n;
      n = 3'h0;
      case (ea[5:3])
         CCSR_EA_DISP: n = 3'h1;
         CCSR_EA_INDEX:
         begin
            n = 3'h1;
            if (first[8])
            begin
               // full format adds base and outer displacement words
               n = n + ((first[5:4] == 2'h3) ? 3'h2 :
                  (first[5:4] == 2'h2) ? 3'h1 : 3'h0);
               n = n + ((first[1:0] == 2'h3) ? 3'h2 :
                  (first[1:0] == 2'h2) ? 3'h1 : 3'h0);
            end
         end
         CCSR_EA_OTHER: n = (ea[2:0] == CCSR_EA_ABS_L) ? 3'h2 : 3'h1;
         default: n = 3'h0;
      endcase
      return n;
   endfunction

   // control alterable or predecrement only
   function automatic logic ea_ok(input logic [5:0] ea);
      case (ea[5:3])
         CCSR_EA_IND, CCSR_EA_PREDEC, CCSR_EA_DISP, CCSR_EA_INDEX:
            return 1'b1;
         CCSR_EA_OTHER:
            return ea[2:0] == CCSR_EA_ABS_W || ea[2:0] == CCSR_EA_ABS_L;
         default: return 1'b0;
      endcase
   endfunction

   ccsr_st_t st, next_st;
   logic [15:0] ext [CCSR_MAX_EXT];
   logic [15:0] next_ext [CCSR_MAX_EXT];
   logic [2:0] ext_cnt, next_ext_cnt;
   logic [5:0] ea_code, next_ea_code;
   logic [15:0] wdata, next_wdata;
   logic [7:0] len, next_len;
   logic [15:0] fmt, next_fmt;
   logic [31:0] ea_val, next_ea_val;
   logic next_done, next_fmt_error, next_fline_exc;
   logic [2:0] need;
   logic op_ok;
   ccsr_kind_t kind;

   assign need = ext_need(ea_code, ext[0]);
   assign kind = ccsr_kind(cir.rdata);
   assign op_ok = save_opword[15:12] == CCSR_OP_FLINE  // [RULE16]
      && save_opword[8:6] == CCSR_OP_SAVE
      && save_opword[11:9] == coproc_select_field;

   ////////////////////////////////////////////////////////////////////
   // handshake towards the coprocessor, decoded from state
   always_comb
   begin
      cir.req = st == S_SAVE_RD || st == S_RST_WR || st == S_RST_RD
         || st == S_ABORT;
      cir.wr = st == S_RST_WR || st == S_ABORT;
      case (st)
         S_RST_WR, S_RST_RD: cir.sel = CCSR_SEL_RESTORE;
         S_ABORT: cir.sel = CCSR_SEL_CONTROL;
         default: cir.sel = CCSR_SEL_SAVE;  // save opens with a read [RULE1]
      endcase
   end
   assign cir.wdata = wdata;
   assign irq_service = st == S_IRQ;
   assign busy = st != S_IDLE;
   assign frame_len = len;
   assign save_fmt = fmt;
   assign frame_ea = ea_val;

   ////////////////////////////////////////////////////////////////////
   // dialogue sequencing
   always_comb
   begin
      next_st = st;
      next_ext = ext;
      next_ext_cnt = ext_cnt;
      next_ea_code = ea_code;
      next_wdata = wdata;
      next_len = len;
      next_fmt = fmt;
      next_ea_val = ea_val;
      next_done = 1'b0;
      next_fmt_error = 1'b0;
      next_fline_exc = 1'b0;
      case (st)
         S_IDLE:
         begin
            next_ext_cnt = 3'h0;
            if (save_start && op_ok)
            begin
               next_ea_code = save_opword[5:0];
               if (!ea_ok(save_opword[5:0]))
                  next_fline_exc = 1'b1;  // [RULE17]
               else
                  next_st = S_EXT;
            end
            else if (save_start)
               next_fline_exc = 1'b1;
            else if (restore_start)
            begin
               next_wdata = restore_fmt;
               next_fmt = restore_fmt;
               next_len = restore_fmt[CCSR_LEN_MSB:CCSR_LEN_LSB]; // [RULE14]
               next_ea_val = areg_value;
               next_st = S_RST_WR;
            end
         end
         S_EXT:
         begin
            if (ext_cnt >= need)
            begin
               // effective address from the gathered words [RULE18]
               case (ea_code[5:3])
                  CCSR_EA_DISP:
                     next_ea_val = areg_value + {{16{ext[0][15]}}, ext[0]};
                  CCSR_EA_INDEX:
                     next_ea_val = areg_value + {{24{ext[0][7]}}, ext[0][7:0]};
                  CCSR_EA_OTHER:
                     next_ea_val = (ea_code[2:0] == CCSR_EA_ABS_L) ?
                        {ext[0], ext[1]} : {{16{ext[0][15]}}, ext[0]};
                  default: next_ea_val = areg_value;
               endcase
               next_st = S_SAVE_RD;
            end
            else if (ext_valid)
            begin
               next_ext[ext_cnt] = ext_word;
               next_ext_cnt = ext_cnt + 3'h1;
            end
         end
         S_SAVE_RD:
            if (cir.ack)
            begin
               next_fmt = cir.rdata;
               case (kind)  // [RULE19] [RULE20]
                  CCSR_K_NOT_READY: next_st = S_IRQ;  // [RULE2]
                  CCSR_K_INVALID: next_st = S_ABORT;  // [RULE12]
                  CCSR_K_VALID:
                  begin
                     next_len = cir.rdata[CCSR_LEN_MSB:CCSR_LEN_LSB]; // [RULE13]
                     next_st = ccsr_len_bad(cir.rdata) ? S_ABORT : S_FIN;
                  end
                  default:
                  begin
                     next_len = 8'h0;  // empty frame has no payload
                     next_st = S_FIN;
                  end
               endcase
            end
         S_IRQ:
            if (irq_done)
               next_st = S_SAVE_RD;  // [RULE2]
         S_RST_WR:
            if (cir.ack)
               next_st = S_RST_RD;
         S_RST_RD:
            if (cir.ack)
               case (kind)
                  CCSR_K_NOT_READY: next_st = S_RST_RD;  // [RULE7]
                  CCSR_K_INVALID: next_st = S_ABORT;  // [RULE9]
                  CCSR_K_VALID:
                     next_st = ccsr_len_bad(fmt) ? S_ABORT : S_FIN; // [RULE15]
                  default: next_st = S_FIN;
               endcase
         S_ABORT:
         begin
            next_wdata = CCSR_ABORT_MASK;  // [RULE10]
            if (cir.ack)
            begin
               next_fmt_error = 1'b1;  // [RULE15]
               next_st = S_IDLE;
            end
         end
         S_FIN:
         begin
            next_done = 1'b1;
            next_st = S_IDLE;
         end
         default: next_st = S_IDLE;
      endcase
      // abort mask must be on the bus before the control write
      if (next_st == S_ABORT)
         next_wdata = CCSR_ABORT_MASK;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st <= S_IDLE;
         for (int i = 0; i < CCSR_MAX_EXT; i++)
            ext[i] <= 16'h0;
         ext_cnt <= 3'h0;
         ea_code <= 6'h0;
         wdata <= 16'h0;
         len <= 8'h0;
         fmt <= 16'h0;
         ea_val <= 32'h0;
         done <= 1'b0;
         fmt_error <= 1'b0;
         fline_exc <= 1'b0;
      end
      else
      begin
         st <= next_st;
         ext <= next_ext;
         ext_cnt <= next_ext_cnt;
         ea_code <= next_ea_code;
         wdata <= next_wdata;
         len <= next_len;
         fmt <= next_fmt;
         ea_val <= next_ea_val;
         done <= next_done;
         fmt_error <= next_fmt_error;
         fline_exc <= next_fline_exc;
      end
   end

endmodule // ccsr_main

// ### verilog/ccsr_cop.sv
// ccsr_cop: coprocessor end of the context save/restore dialogue.
// answers save and restore register accesses with format words and
// takes the abort mask. assumes the main end holds req until ack.
`timescale 1ns/1ps
module ccsr_cop
   import ccsr_pkg::*;
   (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // link to the main processor
   ccsr_if.cop cir,
   // coprocessor core status
   input wire logic op_busy,
   input wire logic state_empty,
   input wire logic [15:0] state_fmt,
   input wire logic restore_hold,
   input wire logic ctx_xfer_done,
   // core control
   output logic suspend_req,
   output logic terminate,
   output logic restore_go,
   output logic [15:0] restore_word,
   output logic abort,
   output logic ctx_busy
   );

   logic next_ack;
   logic [15:0] next_rdata;
   logic next_suspend, next_terminate, next_restore_go, next_abort;
   logic [15:0] reply, next_reply;
   logic [15:0] next_restore_word;
   logic next_ctx_busy;
   logic take;

   assign take = cir.req && !cir.ack;

   ////////////////////////////////////////////////////////////////////
   // register access decode and format-word answers
   always_comb
   begin
      next_ack = take;
      next_rdata = cir.rdata;
      next_suspend = suspend_req && op_busy;
      next_terminate = 1'b0;
      next_restore_go = 1'b0;
      next_abort = 1'b0;
      next_reply = reply;
      next_restore_word = restore_word;
      next_ctx_busy = ctx_busy && !ctx_xfer_done;
      if (take)
         case (cir.sel)
            CCSR_SEL_SAVE:
               if (ctx_busy)
                  next_rdata = CCSR_FMT_INVALID;  // [RULE11]
               else if (op_busy)
               begin
                  next_rdata = CCSR_FMT_NOT_READY;
                  next_suspend = 1'b1;  // [RULE3]
               end
               else
               begin
                  next_rdata = state_empty ? 16'h0 : state_fmt;
                  next_ctx_busy = !state_empty
                     && ccsr_kind(state_fmt) == CCSR_K_VALID;
               end
            CCSR_SEL_RESTORE:
               if (cir.wr)
               begin
                  next_terminate = 1'b1;  // [RULE5]
                  case (ccsr_kind(cir.wdata))
                     CCSR_K_EMPTY: next_reply = cir.wdata;
                     CCSR_K_VALID:
                        if (ccsr_len_bad(cir.wdata))
                           next_reply = CCSR_FMT_INVALID;
                        else
                        begin
                           next_reply = cir.wdata;
                           next_restore_word = cir.wdata;
                           next_restore_go = 1'b1;  // [RULE4]
                           next_ctx_busy = 1'b1;
                        end
                     default: next_reply = CCSR_FMT_INVALID;  // [RULE8]
                  endcase
               end
               else if (restore_hold)
                  next_rdata = CCSR_FMT_NOT_READY;  // [RULE6]
               else
                  next_rdata = reply;
            CCSR_SEL_CONTROL:
               if (cir.wr && cir.wdata[1:0] == CCSR_ABORT_BITS)
               begin
                  next_abort = 1'b1;  // [RULE10]
                  next_ctx_busy = 1'b0;
               end
            default: next_rdata = 16'h0;
         endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cir.ack <= 1'b0;
         cir.rdata <= 16'h0;
         suspend_req <= 1'b0;
         terminate <= 1'b0;
         restore_go <= 1'b0;
         abort <= 1'b0;
         reply <= 16'h0;
         restore_word <= 16'h0;
         ctx_busy <= 1'b0;
      end
      else
      begin
         cir.ack <= next_ack;
         cir.rdata <= next_rdata;
         suspend_req <= next_suspend;
         terminate <= next_terminate;
         restore_go <= next_restore_go;
         abort <= next_abort;
         reply <= next_reply;
         restore_word <= next_restore_word;
         ctx_busy <= next_ctx_busy;
      end
   end

endmodule // ccsr_cop

// ### dv/ccsr_props.sv
// ccsr_props: concurrent checks on the register link between the two
// ends. assumes it is instantiated beside the ccsr_if it watches.
`timescale 1ns/1ps
module ccsr_props
   import ccsr_pkg::*;
   (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // link signals
   input wire logic req,
   input wire logic wr,
   input wire ccsr_sel_t sel,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic [15:0] rdata
   );
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////
   // decoded read answers; reserved codes count as invalid
   logic rd_save;
   logic rd_rest;
   logic code_bad;
   logic code_nr;
   logic len_bad;
   assign rd_save = ack && !wr && sel == CCSR_SEL_SAVE;
   assign rd_rest = ack && !wr && sel == CCSR_SEL_RESTORE;
   assign code_nr = rdata[15:8] == 8'h01;
   assign code_bad = rdata[15:8] >= 8'h02 && rdata[15:8] <= 8'h0f;
   assign len_bad = rdata[15:8] >= 8'h10 && rdata[1:0] != 2'h0;
   sequence s_abort;
      req && wr && sel == CCSR_SEL_CONTROL;
   endsequence
   ////////////////////////////////////////////////////////////////////
   // link handshake and dialogue order
   a_ack_follows: assert property (req && !ack |=> ack)
      else $error("request not answered in one cycle");
   a_req_held: assert property (req && !ack |=> req && $stable({wr, sel,
      wdata}))
      else $error("request changed before its answer");
   a_ack_single: assert property (ack |=> !ack)
      else $error("answer stood longer than one cycle");
   a_save_is_read: assert property (req && sel == CCSR_SEL_SAVE |-> !wr)
      else $error("save register written");
   a_abort_bits: assert property (s_abort |-> wdata[1:0] == 2'h1)
      else $error("abort mask low bits wrong");
   a_restore_reread: assert property (rd_rest && code_nr |-> ##[1:3]
      (req && !wr && sel == CCSR_SEL_RESTORE))
      else $error("restore not reread at once");
   a_save_inv_abort: assert property (rd_save && code_bad |-> ##[1:4]
      s_abort)
      else $error("invalid save word not aborted");
   a_rest_inv_abort: assert property (rd_rest && code_bad |-> ##[1:4]
      s_abort)
      else $error("invalid restore word not aborted");
   a_save_len_abort: assert property (rd_save && len_bad |-> ##[1:4]
      s_abort)
      else $error("bad save length not aborted");
   // main scenarios reached
   c_save_nr: cover property (rd_save && code_nr);
   c_rest_nr: cover property (rd_rest && code_nr);
   c_abort: cover property (s_abort);
endmodule // ccsr_props

// ### dv/tb_top.sv
// tb_top: joins both ends through ccsr_if and checks the save and
// restore dialogue from their user sides. assumes nothing else.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) \
   begin mismatches++; $display("MISMATCH %s exp %h got %h", nm, exp, \
   got); end end
module tb_top;
   import ccsr_pkg::*;
   logic clk_sys = 0;
   logic rst = 1;
   logic save_start = 0, ext_valid = 0, restore_start = 0, irq_done = 0;
   logic [15:0] save_opword = 16'h0, ext_word = 16'h0;
   logic [15:0] restore_fmt = 16'h0, state_fmt = 16'h0;
   logic [2:0] sel_code = 3'h1;
   logic [31:0] areg = 32'h0000_4000;
   logic op_busy = 0, state_empty = 0, restore_hold = 0, xfer_done = 0;
   logic irq_service, done, fmt_error, fline_exc, busy;
   logic [7:0] frame_len;
   logic [15:0] save_fmt, restore_word;
   logic [31:0] frame_ea;
   logic suspend_req, terminate, restore_go, abort, ctx_busy;
   logic [2:0] res;
   int mismatches = 0, n_compared = 0, cyc = 0;
   int n_abort = 0, n_term = 0, n_go = 0, n_srd = 0, n_irq = 0, a0;
   typedef struct {logic [15:0] fmt; logic empty; logic ok;
      logic [15:0] word;} ccsr_row_t;
   ccsr_row_t rows [8];
   ////////////////////////////////////////////////////////////////////
   // clock, link and the two ends
   always #2 clk_sys = ~clk_sys;
   ccsr_if cir_if (.clk_sys(clk_sys), .rst(rst));
   ccsr_main i_ccsr_main (.clk_sys(clk_sys), .rst(rst), .cir(cir_if),
      .save_start(save_start), .save_opword(save_opword),
      .coproc_select_field(sel_code), .ext_valid(ext_valid),
      .ext_word(ext_word), .areg_value(areg),
      .restore_start(restore_start), .restore_fmt(restore_fmt),
      .irq_done(irq_done), .irq_service(irq_service), .done(done),
      .frame_len(frame_len), .save_fmt(save_fmt), .frame_ea(frame_ea),
      .fmt_error(fmt_error), .fline_exc(fline_exc), .busy(busy));
   ccsr_cop i_ccsr_cop (.clk_sys(clk_sys), .rst(rst), .cir(cir_if),
      .op_busy(op_busy), .state_empty(state_empty),
      .state_fmt(state_fmt), .restore_hold(restore_hold),
      .ctx_xfer_done(xfer_done), .suspend_req(suspend_req),
      .terminate(terminate), .restore_go(restore_go),
      .restore_word(restore_word), .abort(abort), .ctx_busy(ctx_busy));
   ccsr_props i_ccsr_props (.clk_sys(clk_sys), .rst(rst),
      .req(cir_if.req), .wr(cir_if.wr), .sel(cir_if.sel),
      .wdata(cir_if.wdata), .ack(cir_if.ack), .rdata(cir_if.rdata));
   ////////////////////////////////////////////////////////////////////
   // event counters; a hang is cut at 5000 cycles, far past the tests
   always @(posedge clk_sys)
   begin
      cyc++;
      n_abort += (abort === 1'b1);
      n_term += (terminate === 1'b1);
      n_go += (restore_go === 1'b1);
      n_irq += (irq_service === 1'b1);
      n_srd += (cir_if.ack === 1'b1 && cir_if.wr === 1'b0 &&
         cir_if.sel === CCSR_SEL_SAVE);
      if (cyc == 5000)
      begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (mismatches == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // waits for the one-cycle outcome pulse {done, fmt_error, fline_exc}
   task automatic wait_end();
      int k;
      // an outcome pulse may already stand when the wait begins
      res = {done, fmt_error, fline_exc};
      for (k = 0; k < 60 && res === 3'h0; k++)
      begin
         @(negedge clk_sys);
         res = {done, fmt_error, fline_exc};
      end
   endtask
   // extension words go one per cycle right after the start pulse
   task automatic do_save(input logic [15:0] op, input int n,
      input logic [15:0] e0, input logic [15:0] e1);
      int i;
      @(negedge clk_sys);
      save_opword = op;
      save_start = 1;
      @(negedge clk_sys);
      save_start = 0;
      for (i = 0; i < n; i++)
      begin
         ext_valid = 1;
         ext_word = (i == 0) ? e0 : e1;
         @(negedge clk_sys);
      end
      ext_valid = 0;
      wait_end();
   endtask
   task automatic do_restore(input logic [15:0] fw);
      @(negedge clk_sys);
      restore_fmt = fw;
      restore_start = 1;
      @(negedge clk_sys);
      restore_start = 0;
      wait_end();
   endtask
   task automatic xfer_end();
      xfer_done = 1;
      @(negedge clk_sys);
      xfer_done = 0;
   endtask
   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      rows = '{'{16'h1004, 1'b1, 1'b1, 16'h0000},
         '{16'h1008, 1'b0, 1'b1, 16'h1008},
         '{16'hff3c, 1'b0, 1'b1, 16'hff3c}, '{16'h1006, 1'b0, 1'b0, 16'h0},
         '{16'h0200, 1'b0, 1'b0, 16'h0}, '{16'h0300, 1'b0, 1'b0, 16'h0},
         '{16'h0f00, 1'b0, 1'b0, 16'h0}, '{16'h1001, 1'b0, 1'b0, 16'h0}};
      repeat (3) @(negedge clk_sys);
      `CHK("busy_rst", 1'b0, busy)
      rst = 0;
      // save answers: empty, valid, bad length, invalid, reserved
      foreach (rows[r])
      begin
         state_fmt = rows[r].fmt;
         state_empty = rows[r].empty;
         a0 = n_abort;
         do_save(16'hf310, 0, 16'h0, 16'h0);
         `CHK("save_out", {rows[r].ok, !rows[r].ok, 1'b0}, res)
         `CHK("abort_n", a0 + !rows[r].ok, n_abort)
         if (rows[r].ok)
         begin
            `CHK("save_fmt", rows[r].word, save_fmt)
            `CHK("frame_len", rows[r].word[7:0], frame_len)
            `CHK("frame_ea", areg, frame_ea)
         end
         xfer_end();
      end
      // save while the core is busy: not-ready, interrupts, reread
      state_fmt = 16'h1010;
      state_empty = 0;
      op_busy = 1;
      a0 = n_srd;
      fork
         do_save(16'hf310, 0, 16'h0, 16'h0);
         begin
            repeat (10) @(negedge clk_sys);
            `CHK("suspend", 1'b1, suspend_req)
            `CHK("irq_wait", 1'b1, irq_service)
            op_busy = 0;
            irq_done = 1;
            @(negedge clk_sys);
            irq_done = 0;
         end
      join
      `CHK("nr_done", 3'h4, res)
      `CHK("reread", 1'b1, n_srd >= a0 + 2)
      `CHK("ctx_open", 1'b1, ctx_busy)
      // second save while the first transfer is still open
      do_save(16'hf310, 0, 16'h0, 16'h0);
      `CHK("busy_save", 3'h2, res)
      `CHK("ctx_free", 1'b0, ctx_busy)
      xfer_end();
      // addressing modes needing extension words
      do_save(16'hf328, 1, 16'h0010, 16'h0);
      `CHK("ea_disp", 32'h0000_4010, frame_ea)
      xfer_end();
      do_save(16'hf339, 2, 16'h1234, 16'h5678);
      `CHK("ea_absl", 32'h1234_5678, frame_ea)
      xfer_end();
      // illegal mode, wrong opmode bits, other select code
      do_save(16'hf300, 0, 16'h0, 16'h0);
      `CHK("fl_mode", 3'h1, res)
      do_save(16'hf350, 0, 16'h0, 16'h0);
      `CHK("fl_op", 3'h1, res)
      do_save(16'hf510, 0, 16'h0, 16'h0);
      `CHK("fl_sel", 3'h1, res)
      // restore held off by the core: reread with no interrupt service
      restore_hold = 1;
      a0 = n_irq;
      fork
         do_restore(16'h1010);
         begin
            repeat (8) @(negedge clk_sys);
            restore_hold = 0;
         end
      join
      `CHK("rst_done", 3'h4, res)
      `CHK("no_irq", a0, n_irq)
      `CHK("rst_len", 8'h10, frame_len)
      `CHK("rst_word", 16'h1010, restore_word)
      `CHK("term_go", 1'b1, n_term > 0 && n_go > 0)
      xfer_end();
      // restore with a frame the core refuses
      a0 = n_abort;
      do_restore(16'h1006);
      `CHK("rst_inv", 3'h2, res)
      `CHK("rst_abort", a0 + 1, n_abort)
      do_restore(16'h0400);
      `CHK("rst_resv", 3'h2, res)
      // reset while a save waits on interrupt service drops both ends
      op_busy = 1;
      fork
         do_save(16'hf310, 0, 16'h0, 16'h0);
         begin
            repeat (6) @(negedge clk_sys);
            rst = 1;
            @(negedge clk_sys);
            `CHK("busy_mid", 1'b0, busy)
            `CHK("irq_mid", 1'b0, irq_service)
            `CHK("susp_mid", 1'b0, suspend_req)
            rst = 0;
         end
      join
      `CHK("res_mid", 3'h0, res)
      op_busy = 0;
      finish_test();
   end
endmodule // tb_top
